/* design/ddr2_state_defs.svh */
// Timing and encoding constants for the DDR2 command state block
`ifndef DDR2_STATE_DEFS_SVH
`define DDR2_STATE_DEFS_SVH

`define BANKS              4
`define BANK_BITS          2
`define BURST_HALF         4'h2
`define WRITE_LATENCY      4'h2
`define WRITE_RECOVERY     4'h2
`define PRECHARGE_CYCLES   4'h3
`define REFRESH_NS         105
`define CLK_PERIOD_NS      5
`define REFRESH_CYCLES     ((`REFRESH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SELF_TIMER_DEFAULT 1560
`define REFRESH_CTR_RESET  2'h0

`endif

/* design/ddr2_state_pkg.sv */
// Types shared by the DDR2 command state block
`default_nettype none
package ddr2_state_pkg;
   typedef enum logic [3:0]
   {
      cmd_deselect,
      cmd_nop,
      cmd_mode_set,
      cmd_refresh,
      cmd_self_refresh,
      cmd_precharge,
      cmd_activate,
      cmd_write,
      cmd_read,
      cmd_power_down,
      cmd_other
   } command_type;

   typedef enum logic [2:0]
   {
      st_normal,
      st_refresh,
      st_self_refresh,
      st_precharge_pd,
      st_active_pd
   } mode_type;
endpackage
`default_nettype wire

/* design/bank_recovery.sv */
// Per-bank write auto-precharge recovery timer
`timescale 1ns/1ps
`default_nettype none
`include "ddr2_state_defs.svh"

module bank_recovery
(
   input  wire logic clk,
   input  wire logic nrst,
   input  wire logic start,
   output logic      precharge_start,
   output logic      busy
);
   localparam logic [3:0] wait_total = `WRITE_LATENCY + `BURST_HALF + `WRITE_RECOVERY;

   logic [3:0] count;
   logic [3:0] next_count;
   logic       next_precharge_start;

   always_comb
   begin
      next_count = count;
      next_precharge_start = 1'b0;
      if (start)
         next_count = wait_total;
      else if (count != 4'h0)
      begin
         next_count = count - 4'h1;
         if (count == 4'h1)
            next_precharge_start = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         count <= 4'h0;
         precharge_start <= 1'b0;
      end
      else
      begin
         count <= next_count;
         precharge_start <= next_precharge_start;
      end
   end

   assign busy = (count != 4'h0);
endmodule
`default_nettype wire

/* design/ddr2_state_ctrl.sv */
// DDR2 command decode, refresh and power state control
// Notes on behaviour
// - Write with A10 high precharges the bank after burst and write recovery.
// - CS RAS CAS low, WE high is refresh; internal counter picks bank.
// - Refresh leaves all banks idle; controller waits tRFC afterwards.
// - Refresh command with CKE falling enters self refresh, banks idle.
// - In self refresh only CKE matters; internal timer refreshes.
// - CKE low with NOP or deselect enters power-down.
// - All banks idle gives precharge power-down, else active power-down.
// - Power-down disables buffers except clock, ODT, CKE; DLL per mode.
// - CKE high with NOP or deselect exits power-down.
// - NOP and deselect register nothing and let bursts finish.
`timescale 1ns/1ps
`default_nettype none
`include "ddr2_state_defs.svh"

module ddr2_state_ctrl
   import ddr2_state_pkg::*;
#(
   parameter int SELF_TIMER = `SELF_TIMER_DEFAULT
)
(
   input  wire logic                  clk,
   input  wire logic                  nrst,
   input  wire logic                  cs_n,
   input  wire logic                  ras_n,
   input  wire logic                  cas_n,
   input  wire logic                  we_n,
   input  wire logic                  cke,
   input  wire logic                  a10,
   input  wire logic [1:0]            bank_addr,
   input  wire logic                  fast_exit,
   output ddr2_state_pkg::mode_type   mode,
   output logic [3:0]                 open_banks,
   output logic [3:0]                 auto_precharge_pulse,
   output logic                       refresh_pulse,
   output logic [1:0]                 refresh_bank,
   output logic                       buffers_on,
   output logic                       dll_on
);
   import ddr2_state_pkg::*;

   localparam int refresh_len = `REFRESH_CYCLES;

   // Pins come from outside, so two flops before any decode
   logic [5:0] pin_meta;
   logic [5:0] pin_sync;
   logic [1:0] bank_meta;
   logic [1:0] bank_sync;
   logic       cke_prev;

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         pin_meta <= 6'h1F;
         pin_sync <= 6'h1F;
         bank_meta <= 2'h0;
         bank_sync <= 2'h0;
         // Matches the idle cke held in the synchroniser, so no false edge
         cke_prev <= 1'b1;
      end
      else
      begin
         pin_meta <= {a10, cke, cs_n, ras_n, cas_n, we_n};
         pin_sync <= pin_meta;
         bank_meta <= bank_addr;
         bank_sync <= bank_meta;
         cke_prev <= pin_sync[4];
      end
   end

   function automatic command_type decode(input logic [3:0] pins, input logic ck_prev, input logic ck_now);
      command_type c;
      c = cmd_other;
      if (pins[3])
         c = cmd_deselect;
      else
         case (pins[2:0])
            3'h7: c = cmd_nop;
            3'h0: c = cmd_mode_set;
            3'h1: c = cmd_refresh;
            3'h2: c = cmd_precharge;
            3'h3: c = cmd_activate;
            3'h4: c = cmd_write;
            3'h5: c = cmd_read;
            default: c = cmd_other;
         endcase
      if (ck_prev && !ck_now && c == cmd_refresh)
         c = cmd_self_refresh;
      else if (ck_prev && !ck_now && (c == cmd_nop || c == cmd_deselect))
         c = cmd_power_down;
      return c;
   endfunction

   command_type cmd;
   logic        cke_now;
   logic [3:0]  ap_start;
   logic [3:0]  ap_fire;
   logic [3:0]  ap_busy;

   assign cke_now = pin_sync[4];
   assign cmd = decode(pin_sync[3:0], cke_prev, cke_now);

   for (genvar b = 0; b < `BANKS; b++)
   begin : g_bank
      bank_recovery u_rec
      (
         .clk             (clk),
         .nrst            (nrst),
         .start           (ap_start[b]),
         .precharge_start (ap_fire[b]),
         .busy            (ap_busy[b])
      );
   end

   mode_type    next_mode;
   logic [3:0]  next_open;
   logic [3:0]  next_ap_pulse;
   logic        next_refresh_pulse;
   logic [1:0]  refresh_ctr;
   logic [1:0]  next_refresh_ctr;
   logic [1:0]  next_refresh_bank;
   logic [15:0] timer;
   logic [15:0] next_timer;
   logic        next_buffers_on;
   logic        next_dll_on;

   always_comb
   begin
      next_mode = mode;
      next_open = open_banks;
      next_ap_pulse = ap_fire;
      next_refresh_pulse = 1'b0;
      next_refresh_ctr = refresh_ctr;
      next_refresh_bank = refresh_bank;
      next_timer = timer;
      ap_start = 4'h0;
      next_open = next_open & ~ap_fire;
      case (mode)
         st_normal:
         begin
            case (cmd)
               cmd_activate:
                  next_open[bank_sync] = 1'b1;
               cmd_precharge:
                  if (pin_sync[5])
                     next_open = 4'h0;
                  else
                     next_open[bank_sync] = 1'b0;
               cmd_write:
                  if (pin_sync[5])
                     ap_start[bank_sync] = 1'b1;
               cmd_refresh:
               begin
                  next_refresh_bank = refresh_ctr;
                  next_refresh_ctr = refresh_ctr + 2'h1;
                  next_refresh_pulse = 1'b1;
                  next_timer = 16'(refresh_len);
                  next_mode = st_refresh;
               end
               cmd_self_refresh:
               begin
                  next_timer = 16'(SELF_TIMER);
                  next_mode = st_self_refresh;
               end
               cmd_power_down:
                  next_mode = (open_banks == 4'h0 && ap_busy == 4'h0) ? st_precharge_pd : st_active_pd;
               default:
                  next_mode = mode;
            endcase
         end
         st_refresh:
         begin
            if (timer > 16'h1)
               next_timer = timer - 16'h1;
            else
            begin
               next_open = 4'h0;
               next_mode = st_normal;
            end
            if (cmd == cmd_power_down)
               next_mode = st_precharge_pd;
         end
         st_self_refresh:
         begin
            if (timer > 16'h1)
               next_timer = timer - 16'h1;
            else
            begin
               next_timer = 16'(SELF_TIMER);
               next_refresh_bank = refresh_ctr;
               next_refresh_ctr = refresh_ctr + 2'h1;
               next_refresh_pulse = 1'b1;
            end
            if (cke_now)
               next_mode = st_normal;
         end
         st_precharge_pd, st_active_pd:
         begin
            if (cke_now && !cke_prev && (cmd == cmd_nop || cmd == cmd_deselect))
               next_mode = st_normal;
         end
         default:
            next_mode = st_normal;
      endcase
      next_buffers_on = !(next_mode == st_precharge_pd || next_mode == st_active_pd
                          || next_mode == st_self_refresh);
      next_dll_on = next_buffers_on || (next_mode == st_active_pd && fast_exit);
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         mode <= st_normal;
         open_banks <= 4'h0;
         auto_precharge_pulse <= 4'h0;
         refresh_pulse <= 1'b0;
         refresh_ctr <= `REFRESH_CTR_RESET;
         refresh_bank <= `REFRESH_CTR_RESET;
         timer <= 16'h0;
         buffers_on <= 1'b1;
         dll_on <= 1'b1;
      end
      else
      begin
         mode <= next_mode;
         open_banks <= next_open;
         auto_precharge_pulse <= next_ap_pulse;
         refresh_pulse <= next_refresh_pulse;
         refresh_ctr <= next_refresh_ctr;
         refresh_bank <= next_refresh_bank;
         timer <= next_timer;
         buffers_on <= next_buffers_on;
         dll_on <= next_dll_on;
      end
   end
endmodule
`default_nettype wire

/* verification/ddr2_ctrl_sva.sv */
// Port assertions for the DDR2 command state block
`timescale 1ns/1ps
`default_nettype none
module ddr2_ctrl_sva
   import ddr2_state_pkg::*;
(
   input wire logic                     clk,
   input wire logic                     nrst,
   input wire logic                     cs_n,
   input wire logic                     ras_n,
   input wire logic                     cas_n,
   input wire logic                     we_n,
   input wire logic                     cke,
   input wire logic                     a10,
   input wire logic [1:0]               bank_addr,
   input wire ddr2_state_pkg::mode_type mode,
   input wire logic [3:0]               open_banks,
   input wire logic [3:0]               auto_precharge_pulse,
   input wire logic                     refresh_pulse,
   input wire logic                     buffers_on,
   input wire logic                     dll_on
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   sequence s_ref_pins;
      !cs_n && !ras_n && !cas_n && we_n;
   endsequence
   sequence s_nop_pins;
      cs_n || (ras_n && cas_n && we_n);
   endsequence
   sequence s_wap_pins;
      !cs_n && ras_n && !cas_n && !we_n && a10 && cke;
   endsequence
   a_ref_pulse: assert property (s_ref_pins ##0 (cke && $past(cke) && mode == st_normal) |-> ##3 refresh_pulse)
      else $error("refresh gave no pulse");
   a_ref_span: assert property ($rose(mode == st_refresh) |-> ##20 mode == st_refresh ##1
      (mode == st_normal && open_banks == 4'h0)) else $error("refresh span wrong");
   a_self_entry: assert property (s_ref_pins ##0 (!cke && $past(cke) && mode == st_normal
      && open_banks == 4'h0) |-> ##3 mode == st_self_refresh) else $error("no self refresh");
   a_self_hold: assert property ((mode == st_self_refresh && !cke)[*3] |=> mode == st_self_refresh)
      else $error("self refresh left");
   a_self_off: assert property (mode == st_self_refresh |-> !buffers_on && !dll_on)
      else $error("buffers on in self refresh");
   a_self_exit: assert property ((mode == st_self_refresh && cke && !$past(cke)) ##0 s_nop_pins
      |-> ##3 mode == st_normal) else $error("self refresh exit late");
   a_pd_kind: assert property (s_nop_pins ##0 (!cke && $past(cke) && mode == st_normal) |-> ##3
      mode == ($past(open_banks) == 4'h0 ? st_precharge_pd : st_active_pd)) else $error("power-down kind");
   a_pd_dll: assert property (mode == st_precharge_pd |-> !dll_on && !buffers_on)
      else $error("dll on in precharge power-down");
   a_pd_exit: assert property (s_nop_pins ##0 (cke && !$past(cke) && mode == st_precharge_pd)
      |-> ##3 mode == st_normal) else $error("power-down exit late");
   a_wap_pulse: assert property (s_wap_pins ##0 ($past(cke) && mode == st_normal) |-> ##10
      auto_precharge_pulse == 4'h1 << $past(bank_addr, 10)) else $error("auto-precharge pulse");
endmodule
bind ddr2_state_ctrl ddr2_ctrl_sva ddr2_ctrl_sva_i
(
   .clk(clk), .nrst(nrst), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .cke(cke),
   .a10(a10), .bank_addr(bank_addr), .mode(mode), .open_banks(open_banks),
   .auto_precharge_pulse(auto_precharge_pulse), .refresh_pulse(refresh_pulse),
   .buffers_on(buffers_on), .dll_on(dll_on)
);
`default_nettype wire

/* verification/ctl_model.sv */
// Memory controller model: turns a command code into pin levels
`timescale 1ns/1ps
`default_nettype none
module ctl_model
   import ddr2_state_pkg::*;
(
   input  wire ddr2_state_pkg::command_type cmd,
   output logic                             cs_n,
   output logic                             ras_n,
   output logic                             cas_n,
   output logic                             we_n
);
   always_comb
   begin
      case (cmd)
         cmd_nop: {cs_n, ras_n, cas_n, we_n} = 4'h7;
         cmd_refresh, cmd_self_refresh: {cs_n, ras_n, cas_n, we_n} = 4'h1;
         cmd_activate: {cs_n, ras_n, cas_n, we_n} = 4'h3;
         cmd_precharge: {cs_n, ras_n, cas_n, we_n} = 4'h2;
         cmd_write: {cs_n, ras_n, cas_n, we_n} = 4'h4;
         // Deselected: other lines carry junk, not a held command
         default: {cs_n, ras_n, cas_n, we_n} = 4'hA;
      endcase
   end
endmodule
`default_nettype wire

/* verification/tb_ddr2_state_ctrl.sv */
// Self-checking bench for the DDR2 command state block
`timescale 1ns/1ps
`default_nettype none
module tb_ddr2_state_ctrl;
   import ddr2_state_pkg::*;
   logic        clk = 1'b0;
   logic        nrst = 1'b0;
   logic        cke = 1'b1;
   logic        a10 = 1'b0;
   logic        fast_exit = 1'b0;
   logic [1:0]  bank_addr = 2'h0;
   command_type cmd = cmd_nop;
   logic        cs_n, ras_n, cas_n, we_n, refresh_pulse, buffers_on, dll_on;
   mode_type    mode;
   logic [3:0]  open_banks, auto_precharge_pulse;
   logic [1:0]  refresh_bank;
   int          err_total = 0;
   int          num_checks = 0;
   int          cycles = 0;
   always #2.5 clk = ~clk;
   ctl_model ctl_model_i (.cmd(cmd), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n));
   ddr2_state_ctrl #(.SELF_TIMER(20)) ddr2_state_ctrl_i
   (
      .clk(clk), .nrst(nrst), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .cke(cke),
      .a10(a10), .bank_addr(bank_addr), .fast_exit(fast_exit), .mode(mode), .open_banks(open_banks),
      .auto_precharge_pulse(auto_precharge_pulse), .refresh_pulse(refresh_pulse),
      .refresh_bank(refresh_bank), .buffers_on(buffers_on), .dll_on(dll_on)
   );
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      num_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(negedge clk);
   endtask
   // One command with its cke level, then nop; returns half a cycle after the sample
   task automatic issue(input command_type c, input logic k);
      @(negedge clk);
      cmd <= c;
      // callers keep each cke level three clocks
      cke <= k;
      @(negedge clk);
      cmd <= cmd_nop;
   endtask
   task automatic t_refresh;
      for (int i = 0; i < 2; i++)
      begin
         issue(cmd_refresh, 1'b1);
         wt(2);
         chk("refresh_pulse", 8'h1, {7'h0, refresh_pulse});
         chk("refresh_bank", 8'(i), {6'h0, refresh_bank});
         chk("mode", 8'(st_refresh), 8'(mode));
         wt(21);
         chk("mode", 8'(st_normal), 8'(mode));
         chk("open_banks", 8'h0, {4'h0, open_banks});
      end
      $display("refresh test done");
   endtask
   task automatic t_write_ap;
      bank_addr <= 2'h2;
      issue(cmd_activate, 1'b1);
      wt(3);
      a10 <= 1'b1;
      issue(cmd_write, 1'b1);
      a10 <= 1'b0;
      wt(8);
      chk("open_banks", 8'h4, {4'h0, open_banks});
      chk("auto_precharge_pulse", 8'h0, {4'h0, auto_precharge_pulse});
      wt(1);
      chk("auto_precharge_pulse", 8'h4, {4'h0, auto_precharge_pulse});
      wt(6);
      chk("open_banks", 8'h0, {4'h0, open_banks});
      $display("write auto-precharge test done");
   endtask
   task automatic t_power_down;
      bank_addr <= 2'h1;
      fast_exit <= 1'b1;
      issue(cmd_activate, 1'b1);
      wt(3);
      issue(cmd_nop, 1'b0);
      wt(3);
      chk("mode", 8'(st_active_pd), 8'(mode));
      chk("dll_buffers", 8'h2, {6'h0, dll_on, buffers_on});
      issue(cmd_nop, 1'b1);
      wt(3);
      chk("mode", 8'(st_normal), 8'(mode));
      wt(3);
      fast_exit <= 1'b0;
      issue(cmd_nop, 1'b0);
      wt(3);
      chk("mode", 8'(st_active_pd), 8'(mode));
      chk("dll_buffers", 8'h0, {6'h0, dll_on, buffers_on});
      issue(cmd_nop, 1'b1);
      wt(3);
      chk("mode", 8'(st_normal), 8'(mode));
      chk("dll_buffers", 8'h3, {6'h0, dll_on, buffers_on});
      wt(3);
      issue(cmd_precharge, 1'b1);
      wt(6);
      issue(cmd_nop, 1'b0);
      wt(3);
      chk("mode", 8'(st_precharge_pd), 8'(mode));
      chk("dll_buffers", 8'h0, {6'h0, dll_on, buffers_on});
      issue(cmd_activate, 1'b0);
      wt(3);
      chk("open_banks", 8'h0, {4'h0, open_banks});
      issue(cmd_nop, 1'b1);
      wt(3);
      chk("mode", 8'(st_normal), 8'(mode));
      $display("power-down test done");
   endtask
   task automatic t_self;
      int n;
      n = 0;
      wt(3);
      issue(cmd_self_refresh, 1'b0);
      wt(3);
      chk("mode", 8'(st_self_refresh), 8'(mode));
      chk("dll_buffers", 8'h0, {6'h0, dll_on, buffers_on});
      issue(cmd_activate, 1'b0);
      repeat (45)
      begin
         @(negedge clk);
         n += refresh_pulse;
      end
      chk("self_pulses", 8'h2, 8'(n));
      chk("open_banks", 8'h0, {4'h0, open_banks});
      issue(cmd_nop, 1'b1);
      wt(3);
      chk("mode", 8'(st_normal), 8'(mode));
      wt(200);
      issue(cmd_refresh, 1'b1);
      wt(2);
      chk("refresh_pulse", 8'h1, {7'h0, refresh_pulse});
      chk("refresh_bank", 8'h0, {6'h0, refresh_bank});
      wt(21);
      $display("self refresh test done");
   endtask
   // Whole run needs under 700 cycles
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         err_total++;
         tally_and_finish();
      end
   end
   initial
   begin
      wt(2);
      nrst <= 1'b1;
      wt(4);
      t_refresh();
      t_write_ap();
      t_power_down();
      t_self();
      tally_and_finish();
   end
endmodule
`default_nettype wire
